// ---- hw/elsb_bank.sv ----
// elsb_bank: serial-slave register bank for event gates and link settings.
// assumes open-drain scl/sda resolved outside; window request, motion and
// event strobes come from the sensing core on sys_clk_in.
`timescale 1ns/1ps
// Summary of operation
// - prox events pass only when bit 0 set
// - touch events gated by bit 1
// - slider events gated by bit 2
// - power-mode events gated by bit 3
// - tuning-done events gated by bit 4
// - tuning-error events gated by bit 6
// - upper byte is settle level, release variant
// - next word upper byte is snapshot wait
// - next word lower byte is release fraction
// - movement variant: word times 512 ms timeout
// - link bit 1 turns off read/write check
// - link bit 0 makes stop keep window open
// - read-only silicon identifier names the variant
// - legacy silicon: link bits stick until reset
// - terminate command ends the window, held or not, unless a core request comes with its stop
// - unmapped reads return 0xEE for lock-up probe
module elsb_bank
   import elsb_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = ELSB_TICK_CYC // cycles per 512 ms
)(
   // clock and reset
   input  wire logic         sys_clk_in,
   input  wire logic         rst_in,
   // straps, caught once after reset release
   input  wire logic         variant_movement_in,
   input  wire logic         legacy_silicon_in,
   // serial pins
   input  wire logic         scl_in,
   input  wire logic         sda_in,
   output logic              sda_out,
   output logic              sda_oe_n_out,
   // sensing core side
   input  wire logic         window_req_in,
   input  wire logic         motion_seen_in,
   input  wire elsb_events_t raw_events_in,
   output elsb_events_t      events_out,
   output logic              window_open_out,
   // settings towards the core
   output logic [7:0]        settle_level_out,
   output logic [7:0]        snapshot_wait_out,
   output logic [7:0]        release_fraction_out,
   output logic [15:0]       motion_expiry_out,
   output logic              motion_expired_out,
   output logic              rw_check_off_out,
   output logic              stop_hold_out
);
   // whole module state in one struct
   typedef struct packed {
      elsb_st_t    st;         // byte engine state
      logic [3:0]  cnt;        // bits seen or presented
      logic [7:0]  sh;         // receive shifter
      logic [7:0]  tx;         // transmit shifter
      logic        rw;         // read direction
      logic [7:0]  ptr;        // register pointer
      logic        bsel;       // 0 low byte, 1 high byte
      logic [7:0]  wlo;        // held low byte of a write
      logic        mack;       // master acked last read byte
      logic        term;       // terminate seen this transfer
      logic        sda_o;      // pin output value, always low
      logic        sda_oe_n;   // low while pulling sda
      logic        scl_q;      // previous filtered scl
      logic        sda_q;      // previous filtered sda
      logic [15:0] ev_reg;     // event gates and settle level
      logic [15:0] ui_reg;     // release settings or motion expiry
      logic [1:0]  link_reg;   // link behaviour bits
      logic        strap_done; // straps taken
      logic        movement;   // movement variant
      logic        legacy;     // sticky link bits
      logic        window;     // communication window open
      logic [23:0] tick;       // cycles inside one 512 ms tick
      logic [15:0] ticks;      // whole ticks since motion
      logic        expired;    // motion timeout reached
   } elsb_state_t;

   elsb_state_t s_ff, nxt_s;
   logic        scl_lvl;   // filtered scl
   logic        sda_lvl;   // filtered sda
   logic        scl_rise;
   logic        scl_fall;
   logic        start_c;
   logic        stop_c;
   logic        writable;  // pointer names a writable word

   // read data for a pointer; unknown pointers give the probe pattern
   function automatic logic [15:0] read_word(input logic [7:0] a,
                                             input elsb_state_t s);
      case (a)
         ELSB_ADDR_EVENTS: read_word = s.ev_reg;
         ELSB_ADDR_UI:     read_word = s.ui_reg;
         ELSB_ADDR_LINK:   read_word = {14'h0000, s.link_reg};
         ELSB_ADDR_HWID:   read_word = s.movement ? ELSB_HWID_MOTION
                                                  : ELSB_HWID_RELEASE;
         default:          read_word = {ELSB_UNMAPPED, ELSB_UNMAPPED};
      endcase
   endfunction : read_word

   // pick the byte of a word, low byte first on the wire
   function automatic logic [7:0] pick_byte(input logic [15:0] w,
                                            input logic        hi);
      pick_byte = hi ? w[15:8] : w[7:0];
   endfunction : pick_byte

   // pin synchronisers
   elsb_pin_sync u_scl_sync (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .pin_in     (scl_in),
      .level_out  (scl_lvl)
   );

   elsb_pin_sync u_sda_sync (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .pin_in     (sda_in),
      .level_out  (sda_lvl)
   );

   // event gating against the enable byte
   elsb_event_gate u_gate (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .raw_in     (raw_events_in),
      .enable_in  (s_ff.ev_reg[7:0]),
      .gated_out  (events_out)
   );

   // bus conditions from filtered levels
   always_comb begin
      scl_rise = scl_lvl & ~s_ff.scl_q;
      scl_fall = ~scl_lvl & s_ff.scl_q;
      start_c  = s_ff.scl_q & scl_lvl & s_ff.sda_q & ~sda_lvl;
      stop_c   = s_ff.scl_q & scl_lvl & ~s_ff.sda_q & sda_lvl;
      writable = (s_ff.ptr == ELSB_ADDR_EVENTS) ||
                 (s_ff.ptr == ELSB_ADDR_UI) ||
                 (s_ff.ptr == ELSB_ADDR_LINK);
   end

   // next state: straps, window, byte engine, writes, motion timer
   always_comb begin
      nxt_s       = s_ff;
      nxt_s.scl_q = scl_lvl;
      nxt_s.sda_q = sda_lvl;
      nxt_s.sda_o = 1'b0;
      // straps sampled on the first clock after release
      if (!s_ff.strap_done) begin
         nxt_s.strap_done = 1'b1;
         nxt_s.movement   = variant_movement_in;
         nxt_s.legacy     = legacy_silicon_in;
      end
      if (start_c) begin
         // start or repeated start restarts addressing
         nxt_s.st       = ELSB_DEV;
         nxt_s.cnt      = 4'h0;
         nxt_s.sda_oe_n = 1'b1;
      end else if (stop_c) begin
         nxt_s.st       = ELSB_IDLE;
         nxt_s.sda_oe_n = 1'b1;
         nxt_s.term     = 1'b0;
         // stop ends the window unless held; terminate does even when held, but a same-cycle core request wins
         if (!s_ff.link_reg[ELSB_LINK_STOP_HOLD] || s_ff.term) begin
            nxt_s.window = 1'b0;
         end
      end else begin
         // sample on rising scl
         if (scl_rise) begin
            case (s_ff.st)
               ELSB_DEV, ELSB_REG, ELSB_WR: begin
                  nxt_s.sh  = {s_ff.sh[6:0], sda_lvl};
                  nxt_s.cnt = s_ff.cnt + 4'h1;
               end
               ELSB_RDACK: begin
                  nxt_s.mack = ~sda_lvl;
               end
               default: begin
                  nxt_s.mack = s_ff.mack;
               end
            endcase
         end
         // act on falling scl
         if (scl_fall) begin
            unique case (s_ff.st)
               ELSB_IDLE: begin
                  nxt_s.sda_oe_n = 1'b1;
               end
               ELSB_DEV: begin
                  if (s_ff.cnt == ELSB_BYTE_BITS) begin
                     if (s_ff.sh[7:1] == ELSB_DEV_ADDR) begin
                        nxt_s.rw       = s_ff.sh[0];
                        nxt_s.sda_oe_n = 1'b0;
                        nxt_s.st       = ELSB_DACK;
                     end else begin
                        nxt_s.st = ELSB_IDLE; // not ours
                     end
                  end
               end
               ELSB_DACK: begin
                  nxt_s.cnt = 4'h0;
                  if (s_ff.rw) begin
                     // read resumes at the held pointer and byte
                     nxt_s.tx       = pick_byte(read_word(s_ff.ptr, s_ff),
                                                s_ff.bsel);
                     nxt_s.sda_oe_n = pick_byte(read_word(s_ff.ptr, s_ff),
                                                s_ff.bsel) >= 8'h80;
                     nxt_s.cnt      = 4'h1;
                     nxt_s.st       = ELSB_RD;
                  end else begin
                     nxt_s.sda_oe_n = 1'b1;
                     nxt_s.st       = ELSB_REG;
                  end
               end
               ELSB_REG: begin
                  if (s_ff.cnt == ELSB_BYTE_BITS) begin
                     nxt_s.ptr      = s_ff.sh;
                     nxt_s.bsel     = 1'b0;
                     nxt_s.sda_oe_n = 1'b0;
                     nxt_s.st       = ELSB_RACK;
                     if (s_ff.sh == ELSB_ADDR_TERM) begin
                        nxt_s.term = 1'b1;
                     end
                  end
               end
               ELSB_RACK, ELSB_WACK: begin
                  nxt_s.sda_oe_n = 1'b1;
                  nxt_s.cnt      = 4'h0;
                  nxt_s.st       = ELSB_WR;
               end
               ELSB_WR: begin
                  if (s_ff.cnt == ELSB_BYTE_BITS) begin
                     // check on: refuse bytes for read-only words
                     nxt_s.sda_oe_n = ~(writable ||
                        s_ff.link_reg[ELSB_LINK_RW_OFF]);
                     nxt_s.st       = ELSB_WACK;
                     nxt_s.bsel     = ~s_ff.bsel;
                     if (!s_ff.bsel) begin
                        nxt_s.wlo = s_ff.sh;
                     end else begin
                        nxt_s.ptr = s_ff.ptr + 8'h01;
                        case (s_ff.ptr)
                           ELSB_ADDR_EVENTS: begin
                              nxt_s.ev_reg[7:0] = s_ff.wlo
                                 & ELSB_EV_MASK;
                              // upper byte only exists on release parts
                              nxt_s.ev_reg[15:8] = s_ff.movement ? 8'h00
                                                 : s_ff.sh;
                           end
                           ELSB_ADDR_UI: begin
                              nxt_s.ui_reg = {s_ff.sh,
                                 s_ff.wlo};
                           end
                           ELSB_ADDR_LINK: begin
                              // legacy parts can only set, reset clears
                              nxt_s.link_reg = s_ff.legacy
                                 ? (s_ff.link_reg | s_ff.wlo[1:0])
                                 : s_ff.wlo[1:0];
                           end
                           default: begin
                              nxt_s.ui_reg = s_ff.ui_reg; // ignored
                           end
                        endcase
                     end
                  end
               end
               ELSB_RD: begin
                  if (s_ff.cnt == ELSB_BYTE_BITS) begin
                     nxt_s.sda_oe_n = 1'b1;
                     nxt_s.st       = ELSB_RDACK;
                     nxt_s.bsel     = ~s_ff.bsel;
                     if (s_ff.bsel) begin
                        nxt_s.ptr = s_ff.ptr + 8'h01;
                     end
                  end else begin
                     nxt_s.tx       = {s_ff.tx[6:0], 1'b0};
                     nxt_s.sda_oe_n = ~s_ff.tx[6] ? 1'b0 : 1'b1;
                     nxt_s.cnt      = s_ff.cnt + 4'h1;
                  end
               end
               ELSB_RDACK: begin
                  if (s_ff.mack) begin
                     nxt_s.tx       = pick_byte(read_word(s_ff.ptr, s_ff),
                                                s_ff.bsel);
                     nxt_s.sda_oe_n = pick_byte(read_word(s_ff.ptr, s_ff),
                                                s_ff.bsel) >= 8'h80;
                     nxt_s.cnt      = 4'h1;
                     nxt_s.st       = ELSB_RD;
                  end else begin
                     nxt_s.st = ELSB_IDLE; // master nack ends read
                  end
               end
               default: begin
                  // illegal code: release the pin and wait
                  nxt_s.sda_oe_n = 1'b1;
                  nxt_s.st       = ELSB_IDLE;
               end
            endcase
         end
      end
      // core request beats a closing stop in the same cycle
      if (window_req_in) begin
         nxt_s.window = 1'b1;
      end
      // motion timeout only counts on movement parts
      if (motion_seen_in || !s_ff.movement) begin
         nxt_s.tick    = 24'h00_0000;
         nxt_s.ticks   = 16'h0000;
         nxt_s.expired = 1'b0;
      end else if (!s_ff.expired && s_ff.ui_reg != 16'h0000) begin
         if (s_ff.tick == 24'(TICK_CYCLES - 1)) begin
            nxt_s.tick  = 24'h00_0000;
            nxt_s.ticks = s_ff.ticks + 16'h0001;
            if (s_ff.ticks + 16'h0001 >= s_ff.ui_reg) begin
               nxt_s.expired = 1'b1;
            end
         end else begin
            nxt_s.tick = s_ff.tick + 24'h00_0001;
         end
      end
   end

   // state register; reset clears every setting
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_ff          <= '0;
         s_ff.st       <= ELSB_IDLE;
         s_ff.sda_oe_n <= 1'b1;
         s_ff.scl_q    <= 1'b1;
         s_ff.sda_q    <= 1'b1;
         s_ff.ev_reg   <= ELSB_RST_WORD;
         s_ff.ui_reg   <= ELSB_RST_WORD;
         s_ff.link_reg <= ELSB_RST_LINK;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // outputs straight from state flops
   assign sda_out              = s_ff.sda_o;
   assign sda_oe_n_out         = s_ff.sda_oe_n;
   assign window_open_out      = s_ff.window;
   assign settle_level_out     = s_ff.ev_reg[15:8];
   assign snapshot_wait_out    = s_ff.ui_reg[15:8];
   assign release_fraction_out = s_ff.ui_reg[7:0];
   assign motion_expiry_out    = s_ff.ui_reg;
   assign motion_expired_out   = s_ff.expired;
   assign rw_check_off_out     = s_ff.link_reg[ELSB_LINK_RW_OFF];
   assign stop_hold_out        = s_ff.link_reg[ELSB_LINK_STOP_HOLD];
endmodule : elsb_bank

// ---- hw/elsb_pkg.sv ----
// elsb_pkg: constants and types for the event and link settings bank.
// assumes a single 25 MHz system clock and byte-wide serial register access.
package elsb_pkg;
   // register word addresses, one 16-bit word per address
   localparam logic [7:0]  ELSB_ADDR_EVENTS  = 8'hD3;
   localparam logic [7:0]  ELSB_ADDR_UI      = 8'hD4;
   localparam logic [7:0]  ELSB_ADDR_LINK    = 8'hE0;
   localparam logic [7:0]  ELSB_ADDR_HWID    = 8'hE1;
   localparam logic [7:0]  ELSB_ADDR_TERM    = 8'hFF; // ends the window
   localparam logic [7:0]  ELSB_UNMAPPED     = 8'hEE; // lock-up probe value
   localparam logic [6:0]  ELSB_DEV_ADDR     = 7'h44; // serial slave address
   // event enable field positions and writable mask
   localparam int          ELSB_EV_PROX      = 0;
   localparam int          ELSB_EV_TOUCH     = 1;
   localparam int          ELSB_EV_SLIDER    = 2;
   localparam int          ELSB_EV_POWER     = 3;
   localparam int          ELSB_EV_TUNE_DONE = 4;
   localparam int          ELSB_EV_TUNE_ERR  = 6;
   localparam logic [7:0]  ELSB_EV_MASK      = 8'h5F;
   // link settings field positions
   localparam int          ELSB_LINK_STOP_HOLD = 0;
   localparam int          ELSB_LINK_RW_OFF    = 1;
   // reset values
   localparam logic [15:0] ELSB_RST_WORD     = 16'h0000;
   localparam logic [1:0]  ELSB_RST_LINK     = 2'h0;
   // identifiers, values arbitrary
   localparam logic [15:0] ELSB_HWID_RELEASE = 16'h5A01;
   localparam logic [15:0] ELSB_HWID_MOTION  = 16'h5A02;
   // timing
   localparam int unsigned ELSB_CLK_HZ       = 25_000_000;
   localparam int unsigned ELSB_TICK_MS      = 512;
   localparam int unsigned ELSB_TICK_CYC     =
      ELSB_TICK_MS * (ELSB_CLK_HZ / 1000);
   localparam logic [3:0]  ELSB_BYTE_BITS    = 4'h8;

   // serial byte engine states, gray along the usual path
   typedef enum logic [3:0] {
      ELSB_IDLE  = 4'h0,
      ELSB_DEV   = 4'h1,
      ELSB_DACK  = 4'h3,
      ELSB_REG   = 4'h2,
      ELSB_RACK  = 4'h6,
      ELSB_WR    = 4'h7,
      ELSB_WACK  = 4'h5,
      ELSB_RD    = 4'h4,
      ELSB_RDACK = 4'hC
   } elsb_st_t;

   // raw or gated event strobes from the sensing core
   typedef struct packed {
      logic tune_err;
      logic tune_done;
      logic power;
      logic slider;
      logic touch;
      logic prox;
   } elsb_events_t;
endpackage : elsb_pkg

// ---- hw/elsb_pin_sync.sv ----
// elsb_pin_sync: three-stage synchroniser with agreement filter for a pin.
// assumes the pin is asynchronous to sys_clk_in and idles high.
`timescale 1ns/1ps
module elsb_pin_sync
   import elsb_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk_in,
   input  wire logic rst_in,
   // pin and filtered level
   input  wire logic pin_in,
   output logic      level_out
);
   typedef struct packed {
      logic s1;  // first stage, read only by s2
      logic s2;
      logic s3;
      logic lvl; // accepted level
   } elsb_sync_t;

   elsb_sync_t s_ff, nxt_s;

   // level moves only once stages two and three agree
   always_comb begin
      nxt_s    = s_ff;
      nxt_s.s1 = pin_in;
      nxt_s.s2 = s_ff.s1;
      nxt_s.s3 = s_ff.s2;
      if (s_ff.s2 == s_ff.s3) begin
         nxt_s.lvl = s_ff.s3;
      end
   end

   // idle-high reset avoids a false start after reset
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_ff <= '1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign level_out = s_ff.lvl;
endmodule : elsb_pin_sync

// ---- hw/elsb_event_gate.sv ----
// elsb_event_gate: passes core event strobes only where enabled.
// assumes raw strobes come from logic on sys_clk_in.
`timescale 1ns/1ps
module elsb_event_gate
   import elsb_pkg::*;
(
   // clock and reset
   input  wire logic         sys_clk_in,
   input  wire logic         rst_in,
   // strobes and enables
   input  wire elsb_events_t raw_in,
   input  wire logic [7:0]   enable_in,
   output elsb_events_t      gated_out
);
   elsb_events_t g_ff, nxt_g;

   // each strobe is dropped while its enable bit is zero
   always_comb begin
      nxt_g           = raw_in;
      nxt_g.prox      &= enable_in[ELSB_EV_PROX];
      nxt_g.touch     &= enable_in[ELSB_EV_TOUCH];
      nxt_g.slider    &= enable_in[ELSB_EV_SLIDER];
      nxt_g.power     &= enable_in[ELSB_EV_POWER];
      nxt_g.tune_done &= enable_in[ELSB_EV_TUNE_DONE];
      nxt_g.tune_err  &= enable_in[ELSB_EV_TUNE_ERR];
   end

   // registered so the top sees flop outputs
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         g_ff <= '0;
      end else begin
         g_ff <= nxt_g;
      end
   end

   assign gated_out = g_ff;
endmodule : elsb_event_gate

// ---- verification/elsb_bank_props.sv ----
// elsb_bank_props: port-level checks of the settings bank.
// assumes straps change only while rst_in is high.
`timescale 1ns/1ps
module elsb_bank_props
   import elsb_pkg::*;
(
   input wire logic         sys_clk_in,
   input wire logic         rst_in,
   input wire logic         variant_movement_in,
   input wire logic         legacy_silicon_in,
   input wire logic         window_req_in,
   input wire logic         motion_seen_in,
   input wire elsb_events_t raw_events_in,
   input wire elsb_events_t events_out,
   input wire logic         window_open_out,
   input wire logic [7:0]   settle_level_out,
   input wire logic [7:0]   snapshot_wait_out,
   input wire logic [7:0]   release_fraction_out,
   input wire logic [15:0]  motion_expiry_out,
   input wire logic         motion_expired_out,
   input wire logic         rw_check_off_out,
   input wire logic         stop_hold_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   // a gated event never appears without its raw strobe one cycle before
   a_event_cause: assert property (((events_out & ~$past(raw_events_in))
      == 6'h00)) else $error("event without raw strobe");
   a_window_open: assert property (window_req_in |=> window_open_out)
      else $error("window not opened");
   a_window_cause: assert property ($rose(window_open_out) |->
      $past(window_req_in)) else $error("window opened unasked");
   // legacy silicon: link bits never fall outside reset
   a_sticky_stop: assert property (legacy_silicon_in && $past(stop_hold_out)
      |-> stop_hold_out) else $error("stop bit cleared");
   a_sticky_rw: assert property (legacy_silicon_in
      && $past(rw_check_off_out) |-> rw_check_off_out)
      else $error("check bit cleared");
   a_settle_motion: assert property (variant_movement_in |->
      settle_level_out == 8'h00) else $error("settle not zero");
   a_expiry_hold: assert property ($fell(motion_expired_out) |->
      $past(motion_seen_in)) else $error("expiry left early");
   a_expiry_variant: assert property (motion_expired_out |->
      variant_movement_in) else $error("expiry on release part");
   a_expiry_set: assert property (motion_expired_out |->
      motion_expiry_out != 16'h0000) else $error("expiry with zero");
   // main scenarios reached
   c_touch: cover property (events_out.touch);
   c_expired: cover property (motion_expired_out);
   c_held: cover property (stop_hold_out && window_open_out);
endmodule : elsb_bank_props
bind elsb_bank elsb_bank_props u_props (.sys_clk_in, .rst_in,
   .variant_movement_in, .legacy_silicon_in, .window_req_in,
   .raw_events_in, .events_out, .window_open_out, .settle_level_out,
   .snapshot_wait_out, .release_fraction_out, .motion_expiry_out,
   .motion_expired_out, .rw_check_off_out, .stop_hold_out, .motion_seen_in);

// ---- verification/elsb_host.sv ----
// elsb_host: serial master model standing in for the host controller.
// assumes the bench resolves sda with a pull-up; scl idles high.
`timescale 1ns/1ps
module elsb_host
   import elsb_pkg::*;
(
   // clock
   input  wire logic clk_in,
   // serial pins
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_out
);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // eight clocks per phase, slow enough for the pin filter
   task automatic hw;
      repeat (8) @(posedge clk_in);
   endtask : hw
   task automatic io(input logic d, output logic r);
      hw;
      sda_out <= d;
      hw;
      scl_out <= 1'b1;
      hw;
      r = sda_in;
      scl_out <= 1'b0;
   endtask : io
   // also serves as repeated start
   task automatic start;
      hw;
      sda_out <= 1'b1;
      hw;
      scl_out <= 1'b1;
      hw;
      sda_out <= 1'b0;
      hw;
      scl_out <= 1'b0;
   endtask : start
   task automatic stop;
      hw;
      sda_out <= 1'b0;
      hw;
      scl_out <= 1'b1;
      hw;
      sda_out <= 1'b1;
      hw;
   endtask : stop
   task automatic tx(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) io(b[i], r);
      io(1'b1, r);
      ack = !r;
   endtask : tx
   task automatic rx(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) io(1'b1, b[i]);
      io(last, r);
   endtask : rx
   // word write, low byte first; ok is the high byte ack
   task automatic wr(input logic [7:0] p, input logic [15:0] d,
                     output logic ok);
      logic a;
      start;
      tx({ELSB_DEV_ADDR, 1'b0}, a);
      tx(p, a);
      tx(d[7:0], a);
      tx(d[15:8], ok);
      stop;
   endtask : wr
   task automatic rd(input logic [7:0] p, output logic [15:0] w);
      logic a;
      start;
      tx({ELSB_DEV_ADDR, 1'b0}, a);
      tx(p, a);
      start;
      tx({ELSB_DEV_ADDR, 1'b1}, a);
      rx(1'b0, w[7:0]);
      rx(1'b1, w[15:8]);
      stop;
   endtask : rd
   // lock-up probe: one byte from a missing word
   task automatic probe(output logic [7:0] b);
      logic [15:0] w;
      rd(8'h10, w);
      b = w[7:0];
   endtask : probe
   // terminate command closes a held window
   task automatic term;
      logic a;
      start;
      tx({ELSB_DEV_ADDR, 1'b0}, a);
      tx(ELSB_ADDR_TERM, a);
      stop;
   endtask : term
endmodule : elsb_host

// ---- verification/event_and_link_settings_bank_bench.sv ----
// event_and_link_settings_bank_bench: register-level tests of the bank.
// assumes elsb_host drives the serial pins; sda pulled up.
`timescale 1ns/1ps
module event_and_link_settings_bank_bench;
   import elsb_pkg::*;
   logic         sys_clk_in, rst_in, mov, leg, win, mot, ok;
   logic         scl_h, sda_h, sda_o, sda_oe_n, sda_w, wo, ex, rwoff;
   logic         shold;
   logic [7:0]   sw, sl, rf;
   logic [15:0]  me, w;
   elsb_events_t raw, ev;
   int           err_total, comparisons;
   int           pos [6] = '{0, 1, 2, 3, 4, 6};
   // open-drain wire: either side may pull low
   assign sda_w = sda_h & (sda_oe_n | sda_o);
   elsb_bank #(.TICK_CYCLES(8)) uut (.sys_clk_in, .rst_in,
      .variant_movement_in(mov), .legacy_silicon_in(leg), .scl_in(scl_h),
      .sda_in(sda_w), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
      .window_req_in(win), .motion_seen_in(mot), .raw_events_in(raw),
      .events_out(ev), .window_open_out(wo), .settle_level_out(sl),
      .snapshot_wait_out(sw), .release_fraction_out(rf),
      .motion_expiry_out(me), .motion_expired_out(ex),
      .rw_check_off_out(rwoff), .stop_hold_out(shold));
   elsb_host host (.clk_in(sys_clk_in), .sda_in(sda_w), .scl_out(scl_h),
      .sda_out(sda_h));
   initial begin
      sys_clk_in = 1'b0;
      forever #20 sys_clk_in = ~sys_clk_in;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // straps only change inside reset
   task automatic rst(input logic m, input logic l);
      rst_in <= 1'b1;
      mov <= m;
      leg <= l;
      repeat (12) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      repeat (6) @(posedge sys_clk_in);
   endtask : rst
   task automatic strobe(input logic [1:0] s, input logic [6:0] n);
      @(posedge sys_clk_in);
      {win, mot} <= s;
      @(posedge sys_clk_in);
      {win, mot} <= 2'b00;
      repeat (n) @(posedge sys_clk_in);
   endtask : strobe
   initial begin
      repeat (60000) @(posedge sys_clk_in);
      err_total++;
      tally_and_finish;
   end
   initial begin
      {rst_in, mov, leg, win, mot} = 5'h10;
      raw = '0;
      rst(1'b0, 1'b0);
      host.rd(ELSB_ADDR_EVENTS, w);
      chk(w, 16'h0000);
      host.rd(ELSB_ADDR_HWID, w);
      chk(w, ELSB_HWID_RELEASE);
      host.probe(w[7:0]);
      chk(w[7:0], 8'hEE);
      host.wr(ELSB_ADDR_EVENTS, 16'hA5FF, ok);
      host.rd(ELSB_ADDR_EVENTS, w);
      chk(w, 16'hA55F);
      chk(sl, 8'hA5);
      // one gate open at a time, every strobe fired together
      for (int k = 0; k < 6; k++) begin
         host.wr(ELSB_ADDR_EVENTS, 16'h0001 << pos[k], ok);
         @(posedge sys_clk_in);
         raw <= '1;
         @(posedge sys_clk_in);
         raw <= '0;
         #1 chk(ev, 16'h0001 << k);
      end
      host.wr(ELSB_ADDR_UI, 16'h3C80, ok);
      chk(sw, 8'h3C);
      chk(rf, 8'h80);
      host.wr(ELSB_ADDR_HWID, 16'h1234, ok);
      chk(ok, 1'b0);
      host.wr(ELSB_ADDR_LINK, 16'hFFFF, ok);
      host.rd(ELSB_ADDR_LINK, w);
      chk(w, 16'h0003);
      chk(rwoff, 1'b1);
      host.wr(ELSB_ADDR_HWID, 16'h1234, ok);
      chk(ok, 1'b1);
      strobe(2'b10, 7'h01);
      chk(wo, 1'b1);
      host.rd(ELSB_ADDR_HWID, w);
      chk(wo, 1'b1);
      host.term;
      chk(wo, 1'b0);
      host.wr(ELSB_ADDR_LINK, 16'h0000, ok);
      chk(shold, 1'b0);
      strobe(2'b10, 7'h01);
      host.rd(ELSB_ADDR_LINK, w);
      chk(wo, 1'b0);
      rst(1'b1, 1'b1);
      host.wr(ELSB_ADDR_LINK, 16'h0001, ok);
      host.wr(ELSB_ADDR_LINK, 16'h0000, ok);
      chk(shold, 1'b1);
      rst(1'b1, 1'b1);
      chk(shold, 1'b0);
      host.rd(ELSB_ADDR_HWID, w);
      chk(w, ELSB_HWID_MOTION);
      host.wr(ELSB_ADDR_EVENTS, 16'hFF01, ok);
      host.rd(ELSB_ADDR_EVENTS, w);
      chk(w, 16'h0001);
      host.wr(ELSB_ADDR_UI, 16'h0002, ok);
      chk(me, 16'h0002);
      chk(ex, 1'b1);
      strobe(2'b01, 7'h08);
      chk(ex, 1'b0);
      repeat (14) @(posedge sys_clk_in);
      chk(ex, 1'b1);
      tally_and_finish;
   end
endmodule : event_and_link_settings_bank_bench
